// >>> rtl/fgs_ahb_slave.sv
/*
  AHB-Lite slave front end: writes with no wait state, reads with
  one wait state so a read right after a write sees the new value.
  assumes a single slave whose hreadyout is the bus hready.
*/
`timescale 1ns/1ps
module fgs_ahb_slave
  import fgs_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // AHB-Lite
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hwrite,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // register file side
  output fgs_wr_t                    wr,
  output logic                       rd_take,
  output logic [FGS_ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]           rd_data
);

  logic                  take;
  logic                  wr_pend;
  logic                  rd_first;
  logic [FGS_ADDR_W-1:0] addr_q;

  // non-word sizes are ignored and answered as idle
  assign take = hsel && htrans[1] && hready && (hsize == FGS_HSIZE_WORD);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      addr_q  <= '0;
    end else if (hready) begin
      wr_pend <= take && hwrite;
      addr_q  <= haddr[FGS_ADDR_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_first <= 1'b0;
    end else begin
      rd_first <= take && !hwrite;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hrdata <= '0;
    end else if (rd_first) begin
      hrdata <= rd_data;
    end
  end

  assign hreadyout = !rd_first;
  assign hresp     = 1'b0;
  assign wr.en     = wr_pend && hready;
  assign wr.addr   = addr_q;
  assign wr.data   = hwdata;
  assign rd_take   = rd_first;
  assign rd_addr   = addr_q;

endmodule // fgs_ahb_slave

// >>> rtl/fgs_gate.sv
/*
  gate of one filter unit: admits commands, counts outstanding
  accesses and reports open or closed. assumes each completion
  pulse matches an access that this gate admitted earlier.
*/
`timescale 1ns/1ps
module fgs_gate
  import fgs_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // control
  input  wire logic        open_request,
  // command channels
  input  wire fgs_fil_in_t fil_in,
  output logic             rd_ready,
  output logic             wr_ready,
  // status
  output logic             open_status,
  output logic             idle
);

  fgs_gate_st_t         state;
  logic [FGS_CNT_W-1:0] cnt;
  logic [FGS_CNT_W-1:0] next_cnt;
  logic [1:0]           n_acc;
  logic [1:0]           n_done;
  logic                 admit;

  //////////////////////////////////////////////////////////////////////
  // stall when closed
  // admission stops at once on a close request, before the drain
  assign admit    = (state == FGS_G_OPEN) && open_request &&
                    (cnt <= FGS_CNT_LIMIT);
  assign rd_ready = admit;
  assign wr_ready = admit;

  assign n_acc  = {1'b0, fil_in.rd_valid & rd_ready} +
                  {1'b0, fil_in.wr_valid & wr_ready};
  assign n_done = {1'b0, fil_in.rd_done} + {1'b0, fil_in.wr_done};

  always_comb begin
    next_cnt = cnt + {{(FGS_CNT_W-2){1'b0}}, n_acc} -
               {{(FGS_CNT_W-2){1'b0}}, n_done};
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= FGS_G_OPEN;
    end else begin
      unique case (state)
        FGS_G_OPEN: begin
          if (!open_request) state <= FGS_G_DRAIN;
        end
        FGS_G_DRAIN: begin
          if (open_request) state <= FGS_G_OPEN;
          else if (cnt == '0) state <= FGS_G_SHUT;
        end
        FGS_G_SHUT: begin
          if (open_request) state <= FGS_G_OPEN;
        end
        default: state <= FGS_G_SHUT;
      endcase
    end
  end

  assign open_status = (state != FGS_G_SHUT);
  assign idle        = (cnt == '0);

endmodule // fgs_gate

// >>> rtl/fgs_pkg.sv
/*
  constants, types and carriers shared by the filter gate and
  lookahead control bank. assumes one clock and a 12-bit decoded
  register window on an AHB-Lite bus.
*/
// Notes on behaviour
// - gate register top half is read-only status; writes there do nothing
// - request and state fields span the implemented filters; rest reads zero
// - state of filter k is shown at bit 16 plus k
// - state bit is one while the gate admits accesses, zero when closed
// - state clears only once admission stopped and outstanding accesses drained
// - one writable request bit per filter sits in the low bits
// - a closed gate holds new commands stalled instead of completing them
// - bits of absent filters are unused, read zero, should be written zero
// - lookahead bit 1 disables write speculation; zero is the default
// - lookahead bit 0 disables read speculation; zero is the default
// - a high virtual network enable forces both disables to zero there
// - lookahead bits 31 to 2 are reserved and read zero
package fgs_pkg;

  localparam int FGS_NUM_FILTERS = 4;
  localparam int FGS_ADDR_W      = 12;
  localparam int FGS_CNT_W       = 8;
  localparam int FGS_STATUS_LSB  = 16;
  localparam int FGS_WSPEC_BIT   = 1;
  localparam int FGS_RSPEC_BIT   = 0;

  localparam logic [FGS_ADDR_W-1:0] FGS_GATE_OFF = 12'h008;
  localparam logic [FGS_ADDR_W-1:0] FGS_SPEC_OFF = 12'h00c;

  localparam logic [2:0] FGS_HSIZE_WORD = 3'h2;

  localparam logic [FGS_NUM_FILTERS-1:0] FGS_REQ_RST  = 4'hf;
  localparam logic [1:0]                 FGS_SPEC_RST = 2'h0;

  // highest count at which two more accesses may still be taken
  localparam logic [FGS_CNT_W-1:0] FGS_CNT_LIMIT = 8'hfd;

  typedef enum logic [2:0] {
    FGS_G_OPEN  = 3'b001,
    FGS_G_DRAIN = 3'b010,
    FGS_G_SHUT  = 3'b100
  } fgs_gate_st_t;

  typedef struct packed {
    logic rd_valid;
    logic wr_valid;
    logic rd_done;
    logic wr_done;
    logic virtual_network_enable_in;
  } fgs_fil_in_t;

  typedef struct packed {
    logic rd_ready;
    logic wr_ready;
    logic rd_spec_off;
    logic wr_spec_off;
  } fgs_fil_out_t;

  typedef struct packed {
    logic                  en;
    logic [FGS_ADDR_W-1:0] addr;
    logic [31:0]           data;
  } fgs_wr_t;

endpackage

// >>> rtl/fgs_top.sv
/*
  filter gate and lookahead control bank: two software registers,
  one gate per filter unit, per-filter speculation disables.
  assumes filter datapaths hand in command valids and completion
  pulses, and an AHB-Lite master with single word transfers.
*/
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module fgs_top
  import fgs_pkg::*;
(
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic [2:0]                  hsize,
  input  wire logic                        hwrite,
  input  wire logic                        hready,
  input  wire logic [31:0]                 hwdata,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  // filter units
  input  wire fgs_fil_in_t [FGS_NUM_FILTERS-1:0]  fil_in,
  output fgs_fil_out_t [FGS_NUM_FILTERS-1:0]      fil_out
);

  localparam int NF = FGS_NUM_FILTERS;

  fgs_wr_t               wr;
  logic                  rd_take;
  logic [FGS_ADDR_W-1:0] rd_addr;
  logic [31:0]           rd_data;
  logic [NF-1:0]         open_request;
  logic [NF-1:0]         open_status;
  logic [NF-1:0]         gate_idle;
  logic [NF-1:0]         rd_ready;
  logic [NF-1:0]         wr_ready;
  logic [NF-1:0]         vn_en;
  logic                  wspec_dis;
  logic                  rspec_dis;

  //////////////////////////////////////////////////////////////////////
  // address decode shared by read and write paths
  function automatic logic reg_hit(
    input logic [FGS_ADDR_W-1:0] a,
    input logic [FGS_ADDR_W-1:0] off
  );
    reg_hit = (a == off);
  endfunction

  fgs_ahb_slave u_bus (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hsize     (hsize),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr        (wr),
    .rd_take   (rd_take),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data)
  );

  //////////////////////////////////////////////////////////////////////
  // gate request bits
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      open_request <= FGS_REQ_RST[NF-1:0];
    end else if (wr.en && reg_hit(wr.addr, FGS_GATE_OFF)) begin
      open_request <= wr.data[NF-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // lookahead disables
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wspec_dis <= FGS_SPEC_RST[FGS_WSPEC_BIT];
      rspec_dis <= FGS_SPEC_RST[FGS_RSPEC_BIT];
    end else if (wr.en && reg_hit(wr.addr, FGS_SPEC_OFF)) begin
      wspec_dis <= wr.data[FGS_WSPEC_BIT];
      rspec_dis <= wr.data[FGS_RSPEC_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // one gate per implemented filter
  genvar k;
  generate
    for (k = 0; k < NF; k++) begin : g_fil
      fgs_gate u_gate (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .open_request (open_request[k]),
        .fil_in       (fil_in[k]),
        .rd_ready     (rd_ready[k]),
        .wr_ready     (wr_ready[k]),
        .open_status  (open_status[k]),
        .idle         (gate_idle[k])
      );

      assign vn_en[k]            = fil_in[k].virtual_network_enable_in;
      assign fil_out[k].rd_ready = rd_ready[k];
      assign fil_out[k].wr_ready = wr_ready[k];
      assign fil_out[k].rd_spec_off = rspec_dis && !vn_en[k];
      assign fil_out[k].wr_spec_off = wspec_dis && !vn_en[k];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets read zero
  always_comb begin
    rd_data = '0;
    if (reg_hit(rd_addr, FGS_GATE_OFF)) begin
      rd_data[NF-1:0] = open_request;
      rd_data[FGS_STATUS_LSB +: NF] = open_status;
    end else if (reg_hit(rd_addr, FGS_SPEC_OFF)) begin
      rd_data[FGS_WSPEC_BIT] = wspec_dis;
      rd_data[FGS_RSPEC_BIT] = rspec_dis;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks on the register bank

  property p_req_write;
    @(posedge ref_clk) disable iff (rst)
    (wr.en && reg_hit(wr.addr, FGS_GATE_OFF)) |=>
      (open_request == $past(wr.data[NF-1:0]));
  endproperty
  a_req_write: assert property (p_req_write)
    else $error("request bits did not take the written value");

  property p_status_ro;
    @(posedge ref_clk) disable iff (rst)
    (wr.en && reg_hit(wr.addr, FGS_GATE_OFF)) |=>
      (((open_status ^ $past(open_status)) &
        (open_status ^ $past(open_request))) == '0);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("write to status half changed the gate state");

  property p_gate_rsvd;
    @(posedge ref_clk) disable iff (rst)
    (rd_take && reg_hit(rd_addr, FGS_GATE_OFF)) |=>
      (hrdata[15:NF] == '0) && (hrdata[31:FGS_STATUS_LSB+NF] == '0);
  endproperty
  a_gate_rsvd: assert property (p_gate_rsvd)
    else $error("reserved gate bits read nonzero");

  property p_status_read;
    @(posedge ref_clk) disable iff (rst)
    (rd_take && reg_hit(rd_addr, FGS_GATE_OFF)) |=>
      (hrdata[FGS_STATUS_LSB +: NF] == $past(open_status)) &&
      (hrdata[NF-1:0] == $past(open_request));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("gate readback does not match state and request");

  property p_spec_read;
    @(posedge ref_clk) disable iff (rst)
    (rd_take && reg_hit(rd_addr, FGS_SPEC_OFF)) |=>
      (hrdata[31:2] == '0) &&
      (hrdata[FGS_WSPEC_BIT] == $past(wspec_dis)) &&
      (hrdata[FGS_RSPEC_BIT] == $past(rspec_dis));
  endproperty
  a_spec_read: assert property (p_spec_read)
    else $error("lookahead readback wrong");

  property p_spec_write;
    @(posedge ref_clk) disable iff (rst)
    (wr.en && reg_hit(wr.addr, FGS_SPEC_OFF)) |=>
      (wspec_dis == $past(wr.data[FGS_WSPEC_BIT])) &&
      (rspec_dis == $past(wr.data[FGS_RSPEC_BIT]));
  endproperty
  a_spec_write: assert property (p_spec_write)
    else $error("lookahead disables did not take the written value");

  property p_read_wait;
    @(posedge ref_clk) disable iff (rst)
    rd_take |-> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state not exactly one cycle");

  //////////////////////////////////////////////////////////////////////
  // registers move only on their own write; a stray update would
  // show up as a silent change of a gate or lookahead setting

  property p_req_hold;
    @(posedge ref_clk) disable iff (rst)
    !(wr.en && reg_hit(wr.addr, FGS_GATE_OFF)) |=>
      $stable(open_request);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request bits changed without a gate write");

  property p_spec_hold;
    @(posedge ref_clk) disable iff (rst)
    !(wr.en && reg_hit(wr.addr, FGS_SPEC_OFF)) |=>
      $stable(wspec_dis) && $stable(rspec_dis);
  endproperty
  a_spec_hold: assert property (p_spec_hold)
    else $error("lookahead disables changed without a write");

  //////////////////////////////////////////////////////////////////////
  // checks on each gate
  generate
    for (k = 0; k < NF; k++) begin : g_chk

      property p_spec_gate;
        @(posedge ref_clk) disable iff (rst)
        !vn_en[k] |->
          (fil_out[k].rd_spec_off == rspec_dis) &&
          (fil_out[k].wr_spec_off == wspec_dis);
      endproperty
      a_spec_gate: assert property (p_spec_gate)
        else $error("effective speculation disable wrong");

      property p_vn_force;
        @(posedge ref_clk) disable iff (rst)
        vn_en[k] |-> !fil_out[k].rd_spec_off && !fil_out[k].wr_spec_off;
      endproperty
      a_vn_force: assert property (p_vn_force)
        else $error("speculation disabled under virtual network");

      property p_closed_stall;
        @(posedge ref_clk) disable iff (rst)
        (!open_status[k] || !open_request[k]) |->
          !rd_ready[k] && !wr_ready[k];
      endproperty
      a_closed_stall: assert property (p_closed_stall)
        else $error("closed gate admitted a command");

      property p_drain_first;
        @(posedge ref_clk) disable iff (rst)
        $fell(open_status[k]) |->
          $past(gate_idle[k]) && !$past(open_request[k]);
      endproperty
      a_drain_first: assert property (p_drain_first)
        else $error("gate closed with accesses outstanding");

      property p_open_follow;
        @(posedge ref_clk) disable iff (rst)
        (open_request[k] && !open_status[k]) |=> open_status[k];
      endproperty
      a_open_follow: assert property (p_open_follow)
        else $error("gate did not open one cycle after request");

      property p_close_follow;
        @(posedge ref_clk) disable iff (rst)
        (!open_request[k] && gate_idle[k] && open_status[k]) |->
          ##[1:2] (!open_status[k] || open_request[k]);
      endproperty
      a_close_follow: assert property (p_close_follow)
        else $error("idle gate did not close within two cycles");

      property p_busy_open;
        @(posedge ref_clk) disable iff (rst)
        (!gate_idle[k] && open_status[k]) |=> open_status[k];
      endproperty
      a_busy_open: assert property (p_busy_open)
        else $error("gate closed while accesses were outstanding");

      property p_status_dir;
        @(posedge ref_clk) disable iff (rst)
        $changed(open_status[k]) |->
          (open_status[k] == $past(open_request[k]));
      endproperty
      a_status_dir: assert property (p_status_dir)
        else $error("gate state moved against its request");

      property p_ready_open;
        @(posedge ref_clk) disable iff (rst)
        (rd_ready[k] || wr_ready[k]) |-> open_status[k];
      endproperty
      a_ready_open: assert property (p_ready_open)
        else $error("gate admitted a command while reported closed");

      property p_shut_empty;
        @(posedge ref_clk) disable iff (rst)
        !open_status[k] |-> gate_idle[k];
      endproperty
      a_shut_empty: assert property (p_shut_empty)
        else $error("closed gate still counts outstanding accesses");

    end
  endgenerate

endmodule // fgs_top

// >>> tb/fgs_tb.sv
/*
  self-checking bench for the filter gate and lookahead bank.
  assumes the bench is the only AHB-Lite master and that it drives
  the filter command channels and completion pulses itself.
*/
`timescale 1ns/1ps
module tb
  import fgs_pkg::*;
();
  localparam logic [31:0] GATE_A = {20'h0, FGS_GATE_OFF};
  localparam logic [31:0] SPEC_A = {20'h0, FGS_SPEC_OFF};

  typedef struct packed {
    logic [31:0] a;
    logic [31:0] wd;
    logic [31:0] exp;
  } fgs_tb_row_t;

  ////////////////////////////////////////////////////////////////////////////
  // design ports
  logic                              ref_clk = 1'b0;
  logic                              rst     = 1'b1;
  logic                              hsel    = 1'b1;
  logic [31:0]                       haddr   = 32'h0;
  logic [1:0]                        htrans  = 2'h0;
  logic [2:0]                        hsize   = 3'h2;
  logic                              hwrite  = 1'b0;
  logic [31:0]                       hwdata  = 32'h0;
  logic                              hreadyout;
  logic                              hresp;
  logic [31:0]                       hrdata;
  fgs_fil_in_t  [FGS_NUM_FILTERS-1:0] fil_in  = '0;
  fgs_fil_out_t [FGS_NUM_FILTERS-1:0] fil_out;

  // bench state
  int                                bad_count   = 0;
  int                                checks_done = 0;
  logic [31:0]                       rd;
  logic [3:0]                        req_sh  = 4'hf;
  logic [1:0]                        spec_sh = 2'h0;

  // ordinary cases: address, written word, word read back
  fgs_tb_row_t rows [10] = '{
    '{GATE_A, 32'hffff_fff5, 32'h0005_0005},
    '{GATE_A, 32'h0000_000f, 32'h000f_000f},
    '{GATE_A, 32'h0000_0000, 32'h0000_0000},
    '{GATE_A, 32'h0000_000f, 32'h000f_000f},
    '{SPEC_A, 32'hffff_ffff, 32'h0000_0003},
    '{SPEC_A, 32'h0000_0002, 32'h0000_0002},
    '{SPEC_A, 32'h0000_0001, 32'h0000_0001},
    '{SPEC_A, 32'h0000_0000, 32'h0000_0000},
    '{32'h010, 32'hffff_ffff, 32'h0000_0000},
    '{32'h000, 32'hffff_ffff, 32'h0000_0000}};

  always #10 ref_clk = ~ref_clk;

  fgs_top fgs_top_inst (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hsize     (hsize),
    .hwrite    (hwrite),
    .hready    (hreadyout),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .fil_in    (fil_in),
    .fil_out   (fil_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask

  // settles at the falling edge, returns on the next rising edge
  task automatic chk_fil(input logic [15:0] exp);
    @(negedge ref_clk);
    checks_done++;
    if (fil_out !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t fil got=%h exp=%h", $time, fil_out, exp);
    end
    @(posedge ref_clk);
  endtask

  function automatic logic [15:0] exp_fil(input logic [3:0] rdy,
                                          input logic [1:0] sp,
                                          input logic [3:0] vn);
    logic [15:0] e;
    for (int k = 0; k < 4; k++) begin
      e[4*k +: 4] = {rdy[k], rdy[k], sp[0] & ~vn[k], sp[1] & ~vn[k]};
    end
    return e;
  endfunction

  // hready is steady from the falling edge up to the sampling edge
  task automatic wait_rdy(output logic [31:0] d);
    @(negedge ref_clk);
    while (hreadyout !== 1'b1) begin
      @(negedge ref_clk);
    end
    d = hrdata;
    @(posedge ref_clk);
  endtask

  // entered right after a rising edge; one single word transfer
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= FGS_HSIZE_WORD;
    wait_rdy(d);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(d);
  endtask

  task automatic wreg(input logic [31:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd, rd);
    chk_reg({31'h0, hresp}, 32'h0);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, rd);
    chk_reg(rd, exp);
  endtask

  task automatic done_pulse(input int k);
    fil_in[k].rd_done <= 1'b1;
    @(posedge ref_clk);
    fil_in[k].rd_done <= 1'b0;
    @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // generous span: the whole sequence needs well under 1000 cycles
  initial begin
    #(20 * 20000);
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rchk(GATE_A, 32'h000f_000f);
    rchk(SPEC_A, 32'h0000_0000);
    chk_fil(exp_fil(4'hf, 2'h0, 4'h0));
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].wd);
      if (rows[i].a == GATE_A) begin
        req_sh = rows[i].wd[3:0];
      end
      if (rows[i].a == SPEC_A) begin
        spec_sh = rows[i].wd[1:0];
      end
      // state needs two cycles to follow an idle close
      repeat (4) @(posedge ref_clk);
      chk_fil(exp_fil(req_sh, spec_sh, 4'h0));
      rchk(rows[i].a, rows[i].exp);
    end
    // two reads in flight, then close and keep commands waiting
    fil_in[2].rd_valid <= 1'b1;
    repeat (2) @(posedge ref_clk);
    fil_in[2].rd_valid <= 1'b0;
    wreg(GATE_A, 32'h0000_000b);
    fil_in[2].rd_valid <= 1'b1;
    fil_in[2].wr_valid <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk_fil(exp_fil(4'hb, 2'h0, 4'h0));
    rchk(GATE_A, 32'h000f_000b);
    done_pulse(2);
    rchk(GATE_A, 32'h000f_000b);
    done_pulse(2);
    repeat (3) @(posedge ref_clk);
    rchk(GATE_A, 32'h000b_000b);
    wreg(GATE_A, 32'h0000_000f);
    // valids stay up until the reopened gate takes both commands
    repeat (2) @(posedge ref_clk);
    fil_in[2].rd_valid <= 1'b0;
    fil_in[2].wr_valid <= 1'b0;
    chk_fil(exp_fil(4'hf, 2'h0, 4'h0));
    rchk(GATE_A, 32'h000f_000f);
    // lookahead disables forced off where the enable is high
    wreg(SPEC_A, 32'h0000_0003);
    rchk(SPEC_A, 32'h0000_0003);
    fil_in[1].virtual_network_enable_in <= 1'b1;
    fil_in[3].virtual_network_enable_in <= 1'b1;
    chk_fil(exp_fil(4'hf, 2'h3, 4'ha));
    // second reset mid-run brings back the defaults
    wreg(GATE_A, 32'h0000_0000);
    // filter 2 still holds the two commands it took after reopening
    repeat (3) @(posedge ref_clk);
    rchk(GATE_A, 32'h0004_0000);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rchk(GATE_A, 32'h000f_000f);
    rchk(SPEC_A, 32'h0000_0000);
    chk_fil(exp_fil(4'hf, 2'h0, 4'ha));
    wrap_up();
  end

endmodule // tb
